/* File: hw/acg_defs.vh */
// constants for the audio clock generator: register offsets, fields, resets, counts
// assumes a single system clock and a simple byte-wide register port
//
// Notes on behaviour
// - converter master clock runs at 256 times the reference sample rate
// - master clock pin feeds divider or loop; 512 kHz to 50 MHz accepted
// - bit clock pin may replace the master clock as source
// - divider mode: reference rate is divider input over 128 times Q, Q 2..17
// - clock source select bits 7:6 pick the divider input
// - clock source select bits 5:4 pick the loop input
// - loop mode: reference rate is input times K times R over 2048 times P
// - K is integer 1..63 plus fraction 0000..9999 in units of 0.0001
// - P in reg 3 bits 2:0, R in reg 11 bits 3:0, J in reg 4 bits 7:2
// - fraction high bits in reg 5, low bits in a further register
// - converter rate is reference rate or twice it over ratio 1..6 step 0.5
// - word clock frequency equals the common converter sampling rate
`ifndef ACG_DEFS_VH
`define ACG_DEFS_VH

// ************************************************************
// register offsets
// ************************************************************
`define ACG_OFS_RATIO       7'h02
`define ACG_OFS_DIVPRE      7'h03
`define ACG_OFS_JMUL        7'h04
`define ACG_OFS_FRAC_HI     7'h05
`define ACG_OFS_FRAC_LO     7'h06
`define ACG_OFS_RATE_CTRL   7'h07
`define ACG_OFS_STATUS      7'h08
`define ACG_OFS_POST        7'h0B
`define ACG_OFS_SRC_SEL     7'h66

// ************************************************************
// reset values
// ************************************************************
`define ACG_RST_RATIO       8'h00
`define ACG_RST_DIVPRE      8'h10
`define ACG_RST_JMUL        8'h04
`define ACG_RST_FRAC_HI     8'h00
`define ACG_RST_FRAC_LO     8'h00
`define ACG_RST_RATE_CTRL   8'h00
`define ACG_RST_POST        8'h01
`define ACG_RST_SRC_SEL     8'h00

// ************************************************************
// field positions
// ************************************************************
`define ACG_LOOP_EN_BIT     7
`define ACG_Q_MSB           6
`define ACG_Q_LSB           3
`define ACG_P_MSB           2
`define ACG_P_LSB           0
`define ACG_J_MSB           7
`define ACG_J_LSB           2
`define ACG_R_MSB           3
`define ACG_R_LSB           0
`define ACG_REC_MSB         7
`define ACG_REC_LSB         4
`define ACG_PLAY_MSB        3
`define ACG_PLAY_LSB        0
`define ACG_DIVSRC_MSB      7
`define ACG_DIVSRC_LSB      6
`define ACG_LOOPSRC_MSB     5
`define ACG_LOOPSRC_LSB     4
`define ACG_DUAL_BIT        0
`define ACG_FLO_MSB         7
`define ACG_FLO_LSB         2

// ************************************************************
// encodings and counts
// ************************************************************
`define ACG_SRC_MCLK        2'b00
`define ACG_SRC_BCLK        2'b01
`define ACG_RATIO_MAX_CODE  4'hA
`define ACG_REF_DIV         12'h100
`define ACG_FRAC_SCALE      20'd10000
`define ACG_FRAC_MAX        14'd9999
`define ACG_LOOP_DEN        26'd160000

`endif

/* File: hw/acg_rate_div.v */
// acg_rate_div: counts step pulses and emits one tick per programmed period
// assumes step is a one-cycle pulse in the system clock domain
`default_nettype none

module acg_rate_div (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        clear,
  input  wire        step,
  input  wire [11:0] period,
  output reg         tick
);

  reg [11:0] cnt_reg;

  // ************************************************************
  // counter
  // ************************************************************
  // clear restarts a whole period, so the first tick is never early
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 12'h000;
      tick    <= 1'b0;
    end else if (clear) begin
      cnt_reg <= 12'h000;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (step) begin
        if (cnt_reg >= period - 12'h001) begin
          cnt_reg <= 12'h000;
          tick    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 12'h001;
        end
      end
    end
  end

endmodule // acg_rate_div

`default_nettype wire

/* File: hw/acg_top.v */
// acg_top: audio clock generator with divider and fractional loop paths
// assumes clock pins are synchronous samples at mclk and far slower than it
`include "acg_defs.vh"
`default_nettype none

module acg_top (
  input  wire       mclk,
  input  wire       resetn,
  input  wire       ext_mclk_in,
  input  wire       bclk_in,
  input  wire [6:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_we,
  input  wire       reg_re,
  output reg  [7:0] reg_rdata,
  output reg        reg_rvalid,
  output reg        conv_mclk_tick,
  output reg        conv_mclk_out,
  output wire       ref_rate_tick,
  output wire       adc_rate_tick,
  output wire       dac_rate_tick,
  output reg        word_clk_out
);

  // ************************************************************
  // registers
  // ************************************************************
  reg [7:0] codec_ratio_select_reg;
  reg [7:0] divider_and_pll_predivide_reg;
  reg [7:0] pll_integer_multiplier_reg;
  reg [7:0] pll_fraction_high_reg;
  reg [7:0] pll_fraction_low_reg;
  reg [7:0] rate_control_reg;
  reg [7:0] pll_post_factor_reg;
  reg [7:0] clock_source_select_reg;
  reg       restart_reg;

  wire mapped_w = (reg_addr == `ACG_OFS_RATIO) || (reg_addr == `ACG_OFS_DIVPRE) ||
                  (reg_addr == `ACG_OFS_JMUL) || (reg_addr == `ACG_OFS_FRAC_HI) ||
                  (reg_addr == `ACG_OFS_FRAC_LO) || (reg_addr == `ACG_OFS_RATE_CTRL) ||
                  (reg_addr == `ACG_OFS_POST) || (reg_addr == `ACG_OFS_SRC_SEL);

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      codec_ratio_select_reg        <= `ACG_RST_RATIO;
      divider_and_pll_predivide_reg <= `ACG_RST_DIVPRE;
      pll_integer_multiplier_reg    <= `ACG_RST_JMUL;
      pll_fraction_high_reg         <= `ACG_RST_FRAC_HI;
      pll_fraction_low_reg          <= `ACG_RST_FRAC_LO;
      rate_control_reg              <= `ACG_RST_RATE_CTRL;
      pll_post_factor_reg           <= `ACG_RST_POST;
      clock_source_select_reg       <= `ACG_RST_SRC_SEL;
      restart_reg                   <= 1'b0;
    end else begin
      // any config write restarts the counters
      restart_reg <= reg_we && mapped_w;
      if (reg_we) begin
        case (reg_addr)
          `ACG_OFS_RATIO:     codec_ratio_select_reg        <= reg_wdata;
          `ACG_OFS_DIVPRE:    divider_and_pll_predivide_reg <= reg_wdata;
          `ACG_OFS_JMUL:      pll_integer_multiplier_reg    <= reg_wdata;
          `ACG_OFS_FRAC_HI:   pll_fraction_high_reg         <= reg_wdata;
          `ACG_OFS_FRAC_LO:   pll_fraction_low_reg          <= reg_wdata;
          `ACG_OFS_RATE_CTRL: rate_control_reg              <= reg_wdata;
          `ACG_OFS_POST:      pll_post_factor_reg           <= reg_wdata;
          `ACG_OFS_SRC_SEL:   clock_source_select_reg       <= reg_wdata;
          default: begin
          end
        endcase
      end
    end
  end

  // ************************************************************
  // field decode
  // ************************************************************
  // ratio code 0..10 means 1.0..6.0 in half steps; larger codes clamp
  function [11:0] rate_period;
    input [3:0] code;
    input       dual;
    reg   [11:0] n;
    begin
      n = {8'h00, (code > `ACG_RATIO_MAX_CODE) ? `ACG_RATIO_MAX_CODE : code} + 12'h002;
      rate_period = dual ? {n[5:0], 6'h00} : {n[4:0], 7'h00};
    end
  endfunction

  wire       loop_en_w   = divider_and_pll_predivide_reg[`ACG_LOOP_EN_BIT];
  wire [3:0] q_code_w    = divider_and_pll_predivide_reg[`ACG_Q_MSB:`ACG_Q_LSB];
  wire [2:0] p_code_w    = divider_and_pll_predivide_reg[`ACG_P_MSB:`ACG_P_LSB];
  wire [5:0] j_code_w    = pll_integer_multiplier_reg[`ACG_J_MSB:`ACG_J_LSB];
  wire [3:0] r_code_w    = pll_post_factor_reg[`ACG_R_MSB:`ACG_R_LSB];
  wire [1:0] div_src_w   = clock_source_select_reg[`ACG_DIVSRC_MSB:`ACG_DIVSRC_LSB];
  wire [1:0] loop_src_w  = clock_source_select_reg[`ACG_LOOPSRC_MSB:`ACG_LOOPSRC_LSB];
  wire       dual_w      = rate_control_reg[`ACG_DUAL_BIT];

  // q codes 0 and 1 stand for 16 and 17
  wire [4:0] q_val_w = (q_code_w < 4'h2) ? {4'h8, q_code_w[0]} : {1'b0, q_code_w};
  // p code 0 stands for 8, r code 0 for 16, j code 0 is treated as 1
  wire [3:0] p_val_w = (p_code_w == 3'h0) ? 4'h8 : {1'b0, p_code_w};
  wire [4:0] r_val_w = (r_code_w == 4'h0) ? 5'h10 : {1'b0, r_code_w};
  wire [5:0] j_val_w = (j_code_w == 6'h00) ? 6'h01 : j_code_w;
  wire [13:0] d_raw_w = {pll_fraction_high_reg, pll_fraction_low_reg[`ACG_FLO_MSB:`ACG_FLO_LSB]};
  wire [13:0] d_val_w = (d_raw_w > `ACG_FRAC_MAX) ? `ACG_FRAC_MAX : d_raw_w;

  // k scaled by 10000: integer part plus fraction digits
  wire [19:0] k_scaled_w = {14'h0000, j_val_w} * `ACG_FRAC_SCALE + {6'h00, d_val_w};
  wire [25:0] loop_inc_w = {6'h00, k_scaled_w} * {21'h0, r_val_w};
  wire [25:0] loop_thr_w = {22'h0, p_val_w} * `ACG_LOOP_DEN;

  // ************************************************************
  // source selection and edge detect
  // ************************************************************
  reg  mclk_pin_reg;
  reg  bclk_pin_reg;
  reg  div_src_reg;
  reg  loop_src_reg;

  wire active_src_sel_w = loop_en_w ? loop_src_w[1] : div_src_w[1];
  wire src_missing_w    = active_src_sel_w;

  // picks pin level by select; codes 1x select no source, so the clock stops
  function pick_src;
    input [1:0] sel;
    input       mclk_lvl;
    input       bclk_lvl;
    begin
      case (sel)
        `ACG_SRC_MCLK: pick_src = mclk_lvl;
        `ACG_SRC_BCLK: pick_src = bclk_lvl;
        default:       pick_src = 1'b0;
      endcase
    end
  endfunction

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mclk_pin_reg <= 1'b0;
      bclk_pin_reg <= 1'b0;
      div_src_reg  <= 1'b0;
      loop_src_reg <= 1'b0;
    end else begin
      mclk_pin_reg <= ext_mclk_in;
      bclk_pin_reg <= bclk_in;
      div_src_reg  <= pick_src(div_src_w, mclk_pin_reg, bclk_pin_reg);
      loop_src_reg <= pick_src(loop_src_w, mclk_pin_reg, bclk_pin_reg);
    end
  end

  // both edges count, so a divide by q gives 2 * src / q = 256 * ref rate
  wire div_edge_w  = div_src_reg ^ pick_src(div_src_w, mclk_pin_reg, bclk_pin_reg);
  wire loop_edge_w = loop_src_reg ^ pick_src(loop_src_w, mclk_pin_reg, bclk_pin_reg);

  // ************************************************************
  // divider and fractional loop
  // ************************************************************
  reg  [4:0]  div_cnt_reg;
  reg  [4:0]  div_cnt_next;
  reg  [25:0] loop_acc_reg;
  reg  [25:0] loop_acc_next;
  reg         tick_next;

  always @* begin
    div_cnt_next  = div_cnt_reg;
    loop_acc_next = loop_acc_reg;
    tick_next     = 1'b0;
    if (!loop_en_w) begin
      // ref = in / (128 * q)
      if (div_edge_w) begin
        if (div_cnt_reg >= q_val_w - 5'h01) begin
          div_cnt_next = 5'h00;
          tick_next    = 1'b1;
        end else begin
          div_cnt_next = div_cnt_reg + 5'h01;
        end
      end
    end else begin
      // ref = in * k * r / (2048 * p), by phase accumulation
      // one tick per cycle at most, fine while output is far below 125 MHz
      if (loop_acc_reg >= loop_thr_w) begin
        tick_next = 1'b1;
      end
      loop_acc_next = loop_acc_reg + (loop_edge_w ? loop_inc_w : 26'h0000000)
                      - (tick_next ? loop_thr_w : 26'h0000000);
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_reg    <= 5'h00;
      loop_acc_reg   <= 26'h0000000;
      conv_mclk_tick <= 1'b0;
      conv_mclk_out  <= 1'b0;
    end else if (restart_reg) begin
      // level kept, phase restarted: the next edge is a full new period away
      div_cnt_reg    <= 5'h00;
      loop_acc_reg   <= 26'h0000000;
      conv_mclk_tick <= 1'b0;
    end else begin
      div_cnt_reg    <= div_cnt_next;
      loop_acc_reg   <= loop_acc_next;
      conv_mclk_tick <= tick_next;
      if (tick_next) begin
        conv_mclk_out <= ~conv_mclk_out;
      end
    end
  end

  // ************************************************************
  // rate derivation
  // ************************************************************
  wire [11:0] adc_period_w = rate_period(codec_ratio_select_reg[`ACG_REC_MSB:`ACG_REC_LSB],
                                         dual_w);
  wire [11:0] dac_period_w = rate_period(codec_ratio_select_reg[`ACG_PLAY_MSB:`ACG_PLAY_LSB],
                                         dual_w);
  wire        wclk_half_tick_w;

  acg_rate_div u_ref_div (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (restart_reg),
    .step   (conv_mclk_tick),
    .period (`ACG_REF_DIV),
    .tick   (ref_rate_tick)
  );

  acg_rate_div u_adc_div (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (restart_reg),
    .step   (conv_mclk_tick),
    .period (adc_period_w),
    .tick   (adc_rate_tick)
  );

  acg_rate_div u_dac_div (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (restart_reg),
    .step   (conv_mclk_tick),
    .period (dac_period_w),
    .tick   (dac_rate_tick)
  );

  // half period of the playback rate, so the square wave runs at that rate
  acg_rate_div u_wclk_div (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (restart_reg),
    .step   (conv_mclk_tick),
    .period ({1'b0, dac_period_w[11:1]}),
    .tick   (wclk_half_tick_w)
  );

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      word_clk_out <= 1'b0;
    end else if (restart_reg) begin
      word_clk_out <= 1'b0;
    end else if (wclk_half_tick_w) begin
      word_clk_out <= ~word_clk_out;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_re;
      if (reg_re) begin
        case (reg_addr)
          `ACG_OFS_RATIO:     reg_rdata <= codec_ratio_select_reg;
          `ACG_OFS_DIVPRE:    reg_rdata <= divider_and_pll_predivide_reg;
          `ACG_OFS_JMUL:      reg_rdata <= pll_integer_multiplier_reg;
          `ACG_OFS_FRAC_HI:   reg_rdata <= pll_fraction_high_reg;
          `ACG_OFS_FRAC_LO:   reg_rdata <= {pll_fraction_low_reg[7:2], 2'b00};
          `ACG_OFS_RATE_CTRL: reg_rdata <= {7'h00, rate_control_reg[0]};
          `ACG_OFS_POST:      reg_rdata <= {4'h0, pll_post_factor_reg[3:0]};
          `ACG_OFS_SRC_SEL:   reg_rdata <= {clock_source_select_reg[7:4], 4'h0};
          `ACG_OFS_STATUS:    reg_rdata <= {5'h00, conv_mclk_out, src_missing_w, loop_en_w};
          default:            reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // acg_top

`default_nettype wire

/* File: verification/acg_checker.sv */
// acg_checker: timing relations on the register port and the clock ticks
// assumes it is bound onto acg_top and sees only its ports
`default_nettype none
module acg_checker (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_we,
  input wire logic       reg_re,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       conv_mclk_tick,
  input wire logic       conv_mclk_out,
  input wire logic       ref_rate_tick,
  input wire logic       adc_rate_tick,
  input wire logic       dac_rate_tick,
  input wire logic       word_clk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ************************************************************
  // register port
  // ************************************************************
  property p_rd_lat; reg_re |=> reg_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_quiet; !reg_re |=> !reg_rvalid; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("spurious read valid");
  property p_rd_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped; reg_re && reg_addr == 7'h10 |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_wr_rd;
    (reg_we && reg_addr == 7'h02) ##1 !reg_we ##1 (reg_re && reg_addr == 7'h02)
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("ratio readback wrong");
  // ************************************************************
  // clock ticks
  // ************************************************************
  // slack of up to two cycles, since each rate pulse is registered from a tick
  property p_out_chg;
    $changed(conv_mclk_out) |-> conv_mclk_tick || $past(conv_mclk_tick);
  endproperty
  a_out_chg: assert property (p_out_chg) else $error("clock out moved alone");
  property p_tick_out; conv_mclk_tick |-> ##[0:1] $changed(conv_mclk_out); endproperty
  a_tick_out: assert property (p_tick_out) else $error("clock out missed tick");
  property p_ref;
    ref_rate_tick |-> conv_mclk_tick || $past(conv_mclk_tick) || $past(conv_mclk_tick, 2);
  endproperty
  a_ref: assert property (p_ref) else $error("ref tick without clock tick");
  property p_adc;
    adc_rate_tick |-> conv_mclk_tick || $past(conv_mclk_tick) || $past(conv_mclk_tick, 2);
  endproperty
  a_adc: assert property (p_adc) else $error("adc tick without clock tick");
  property p_dac;
    dac_rate_tick |-> conv_mclk_tick || $past(conv_mclk_tick) || $past(conv_mclk_tick, 2);
  endproperty
  a_dac: assert property (p_dac) else $error("dac tick without clock tick");
endmodule // acg_checker
bind acg_top acg_checker i_chk (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .conv_mclk_tick(conv_mclk_tick), .conv_mclk_out(conv_mclk_out),
  .ref_rate_tick(ref_rate_tick), .adc_rate_tick(adc_rate_tick),
  .dac_rate_tick(dac_rate_tick), .word_clk_out(word_clk_out));
`default_nettype wire

/* File: verification/acg_clk_src.sv */
// acg_clk_src: external master clock and bit clock pins for the generator
// assumes half periods counted in mclk cycles; zero holds a pin low
`default_nettype none
module acg_clk_src (
  input  wire logic       mclk,
  input  wire logic [7:0] half_m,
  input  wire logic [7:0] half_b,
  output wire logic       ext_mclk_in,
  output wire logic       bclk_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m_q = 1'b0;
  logic b_q = 1'b0;
  int   cm  = 0;
  int   cb  = 0;
  assign ext_mclk_in = m_q;
  assign bclk_in     = b_q;
  // halves of 2..122 keep the pin inside 512 kHz to 31 MHz
  // stopped pins stand low, so no stray edges between scenarios
  always @(negedge mclk) begin
    cm = cm + 1;
    cb = cb + 1;
    if (half_m == 8'h00) m_q = 1'b0;
    else if (cm >= half_m) begin
      m_q = ~m_q;
      cm = 0;
    end
    if (half_b == 8'h00) b_q = 1'b0;
    else if (cb >= half_b) begin
      b_q = ~b_q;
      cb = 0;
    end
  end
endmodule // acg_clk_src
`default_nettype wire

/* File: verification/acg_top_tb.sv */
// acg_top_tb: register table, divider, loop and ratio scenarios for acg_top
// assumes acg_top, acg_clk_src and acg_checker are compiled before it
`default_nettype none
module acg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [6:0]  reg_addr = 7'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic [7:0]  half_m = 8'h04;
  logic [7:0]  half_b = 8'h00;
  logic        wclk_d = 1'b0;
  wire logic   ext_mclk_in, bclk_in, conv_mclk_tick, conv_mclk_out, reg_rvalid;
  wire logic   ref_rate_tick, adc_rate_tick, dac_rate_tick, word_clk_out;
  wire logic [7:0] reg_rdata;
  wire logic   wclk_rise = word_clk_out & ~wclk_d;
  int          miscompares = 0;
  int          compares = 0;
  int          n;
  logic [14:0] rows [9] = '{15'h0200, 15'h0310, 15'h0404, 15'h0500, 15'h0600,
                            15'h0700, 15'h0B01, 15'h6600, 15'h1000};
  logic [3:0]  qc [4] = '{4'h2, 4'h5, 4'h0, 4'h1};
  int          qv [4] = '{2, 5, 16, 17};
  logic [7:0]  rrat [2] = '{8'h11, 8'h22};
  logic [7:0]  rdual [2] = '{8'h00, 8'h01};
  int          rexp [2] = '{1536, 1024};
  acg_top i_dut (.mclk(mclk), .resetn(resetn), .ext_mclk_in(ext_mclk_in), .bclk_in(bclk_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_mclk_tick(conv_mclk_tick),
    .conv_mclk_out(conv_mclk_out), .ref_rate_tick(ref_rate_tick),
    .adc_rate_tick(adc_rate_tick), .dac_rate_tick(dac_rate_tick),
    .word_clk_out(word_clk_out));
  acg_clk_src i_src (.mclk(mclk), .half_m(half_m), .half_b(half_b),
    .ext_mclk_in(ext_mclk_in), .bclk_in(bclk_in));
  always @(posedge mclk) wclk_d <= word_clk_out;
  initial begin
    forever #4 mclk = ~mclk;
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic give_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge mclk);
    reg_we = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_re = 1'b1;
    // the answer stands one cycle only, so it is taken at the very next falling edge
    @(negedge mclk);
    reg_re = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk({24'h0, reg_rdata}, {24'h0, e});
  endtask
  function automatic logic sig(input int sel);
    case (sel)
      0: return conv_mclk_tick;
      1: return ref_rate_tick;
      2: return adc_rate_tick;
      3: return dac_rate_tick;
      default: return wclk_rise;
    endcase
  endfunction
  task automatic wait_hi(input int sel, output int c);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (sig(sel) !== 1'b1 && c < 40000);
    if (c >= 40000) begin
      miscompares++;
      give_verdict();
    end
  endtask
  // third interval, so a tick left over from before a restart is skipped
  task automatic meas(input int sel, input int exp);
    int c;
    wait_hi(sel, c);
    wait_hi(sel, c);
    wait_hi(sel, c);
    chk(c, exp);
  endtask
  task automatic count(input int cyc, output int k);
    k = 0;
    repeat (cyc) begin
      @(negedge mclk);
      if (conv_mclk_tick === 1'b1) k++;
    end
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    for (int i = 0; i < 9; i++) rd(rows[i][14:8], rows[i][7:0]);
    wr(7'h10, 8'h5A);
    rd(7'h10, 8'h00);
    wr(7'h02, 8'h11);
    rd(7'h02, 8'h11);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(7'h03, {1'b0, qc[i], 3'b000});
      meas(0, 4 * qv[i]);
    end
    half_b = 8'h03;
    wr(7'h66, 8'h40);
    wr(7'h03, 8'h10);
    meas(0, 6);
    wr(7'h66, 8'h80);
    count(300, n);
    chk(n, 0);
    $display("test divider done");
    half_m = 8'h02;
    wr(7'h66, 8'h00);
    meas(1, 1024);
    // half-integer ratio only with even q, and both ratio fields equal
    for (int i = 0; i < 2; i++) begin
      wr(7'h02, rrat[i]);
      wr(7'h07, rdual[i]);
      meas(2, rexp[i]);
      meas(3, rexp[i]);
      meas(4, rexp[i]);
    end
    wr(7'h02, 8'hFF);
    wr(7'h07, 8'h00);
    meas(3, 6144);
    $display("test ratios done");
    wr(7'h03, 8'h81);
    wr(7'h04, 8'h20);
    meas(0, 4);
    // p code 0 and r code 0 stand for 8 and 16, which with j of 8 give one tick per edge
    wr(7'h0B, 8'h00);
    wr(7'h03, 8'h80);
    meas(0, 2);
    wr(7'h03, 8'h82);
    wr(7'h04, 8'h10);
    wr(7'h0B, 8'h02);
    meas(0, 8);
    wr(7'h66, 8'h10);
    wr(7'h03, 8'h81);
    wr(7'h04, 8'h20);
    wr(7'h0B, 8'h01);
    meas(0, 6);
    wr(7'h66, 8'h00);
    wr(7'h04, 8'h10);
    wr(7'h05, 8'h4E);
    wr(7'h06, 8'h20);
    repeat (4) @(negedge mclk);
    count(3200, n);
    chk({31'h0, n >= 449 && n <= 451}, 32'h1);
    $display("test loop done");
    // the master clock pin stands still from here and the bit clock pin is never selected, so the status byte is fully known
    half_m = 8'h00;
    resetn = 1'b0;
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    rd(7'h03, 8'h10);
    rd(7'h08, 8'h00);
    wr(7'h66, 8'h80);
    rd(7'h08, 8'h02);
    wr(7'h03, 8'h80);
    rd(7'h08, 8'h01);
    $display("test second reset done");
    give_verdict();
  end
endmodule // acg_top_tb
`default_nettype wire
